// File: rtl/pit_pkg.sv
// constants shared by both ends of the interval timer link
package pit_pkg;
  // clock and prescaler
  localparam int unsigned SYS_CLK_HZ        = 25000000;
  localparam int unsigned PRESCALE_DIV      = 8;
  localparam logic [2:0]  PRESCALE_LAST     = 3'h7;
  localparam logic [2:0]  PRESCALE_START    = 3'h5;
  localparam logic [2:0]  MCYC_ADDR_PHASE   = 3'h1;
  localparam logic [2:0]  MCYC_DATA_PHASE   = 3'h5;
  // counter geometry
  localparam int unsigned CNT_STAGES        = 24;
  localparam int unsigned CNT_LOW_BYPASS    = 8;
  // control byte fields
  localparam int unsigned CTL_SEL_LSB       = 0;
  localparam int unsigned CTL_SEL_W         = 4;
  localparam int unsigned CTL_SHORT_BIT     = 4;
  localparam int unsigned CTL_SET_BIT       = 5;
  localparam int unsigned CTL_CLR_BIT       = 6;
  localparam int unsigned CTL_HOLD_BIT      = 7;
  localparam logic [7:0]  CTL_RESET_VAL     = 8'h40;
  // grouped i/o codes
  localparam logic [7:0]  GROUP_TIMER       = 8'h08;
  localparam logic [7:0]  GROUP_NONE        = 8'h00;
  localparam logic [2:0]  CMD_GROUP_SEL     = 3'h1;
  localparam logic [2:0]  CMD_TIMER_CTL     = 3'h3;
  // host software port
  localparam logic [1:0]  HOST_ADDR_CTL     = 2'h0;
  localparam logic [1:0]  HOST_ADDR_GROUP   = 2'h1;
  localparam logic [1:0]  HOST_ADDR_STATUS  = 2'h2;
endpackage

// File: rtl/pit_link_if.sv
// link between the host cpu end and the timer end
`timescale 1ns/1ps
interface pit_link_if;
  logic       io_strobe;
  logic [2:0] io_cmd;
  logic [7:0] io_data;
  logic       address_timing_pulse;
  logic       data_timing_pulse;
  logic       cpu_flag_line_two;
  logic       irq;
  modport timer (input io_strobe, io_cmd, io_data, address_timing_pulse, data_timing_pulse,
                 output cpu_flag_line_two, irq);
  modport host  (output io_strobe, io_cmd, io_data, address_timing_pulse, data_timing_pulse,
                 input cpu_flag_line_two, irq);
endinterface

// File: rtl/pit_timer.sv
// interval timer end: prescaler, 24-stage counter, flag flip-flop, group latch
`timescale 1ns/1ps
// Functional notes
// - prescaler divides system clock by eight
// - 24-stage counter with set, reset, pause
// - flag shown on flag two when grouped
// - control write clears flag and interrupt
// - host selects group 08 then command 3
// - bits 0-3 pick one of top 16
// - bit 4 bypasses eight low stages
// - bit 5 sets all, bit 6 clears
// - bit 7 holds count unchanged
// - free run gives square wave, flag per period
// - from zero full period, ones one tick
// - clear release starts one-shot from zero
// - selected stage falling ends shot, sets flag
// - set start output high, flag after one tick
// - clear or set restarts timing cycle
// - external clear pin acts like bit 6
// - selected output drives connector pin
// - restart at data pulse: first tick three clocks
// - one tick per machine cycle, mid cycle
// - counting ignores cpu wait states
// - control resets with clear set, pause not set
// - reset clears group select latch
module pit_timer (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic resetn_in,
  // cpu link
  pit_link_if.timer link,
  // board pins
  input  wire logic ext_clear_in,
  input  wire logic irq_link_jumper_in,
  output logic      timer_out
);
  // control and group state
  logic [7:0]  ctl_r;
  logic [7:0]  ctl_nxt;
  logic [7:0]  group_r;
  logic [7:0]  group_nxt;
  // prescaler and counter state
  logic [2:0]  pre_r;
  logic [2:0]  pre_nxt;
  logic [23:0] cnt_r;
  logic [23:0] cnt_nxt;
  // output and flag state
  logic        out_r;
  logic        out_nxt;
  logic        flag_r;
  logic        flag_nxt;
  // decoded strobes and levels
  logic        grp_wr;
  logic        ctl_wr;
  logic        grouped;
  logic        force_set;
  logic        force_clr;
  logic        hold;
  logic        tick;
  logic        realign;
  logic        fall_evt;
  logic        sel_bit;
  logic [3:0]  sel_idx;
  logic [23:0] inc;

  assign grouped   = group_r == pit_pkg::GROUP_TIMER;
  assign grp_wr    = link.io_strobe && link.io_cmd == pit_pkg::CMD_GROUP_SEL;
  assign ctl_wr    = link.io_strobe && link.io_cmd == pit_pkg::CMD_TIMER_CTL
                     && grouped;
  assign force_set = ctl_r[pit_pkg::CTL_SET_BIT];
  assign force_clr = ctl_r[pit_pkg::CTL_CLR_BIT] || ext_clear_in;
  assign hold      = ctl_r[pit_pkg::CTL_HOLD_BIT];
  // realign only when leaving the clear-and-hold parking state in one write
  assign realign   = ctl_wr
                     && ctl_r[pit_pkg::CTL_CLR_BIT] && ctl_r[pit_pkg::CTL_HOLD_BIT]
                     && !link.io_data[pit_pkg::CTL_CLR_BIT]
                     && !link.io_data[pit_pkg::CTL_HOLD_BIT];
  // prescaler is free running so cpu wait states never stall it
  assign tick      = pre_r == pit_pkg::PRESCALE_LAST;
  assign sel_idx   = ctl_r[pit_pkg::CTL_SEL_LSB +: pit_pkg::CTL_SEL_W];

  // group latch
  always_comb begin
    group_nxt = group_r;
    if (grp_wr)
      group_nxt = link.io_data;
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      group_r <= pit_pkg::GROUP_NONE;
    end else begin
      group_r <= group_nxt;
    end
  end

  // control byte
  always_comb begin
    ctl_nxt = ctl_r;
    if (ctl_wr)
      ctl_nxt = link.io_data;
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      ctl_r <= pit_pkg::CTL_RESET_VAL;
    end else begin
      ctl_r <= ctl_nxt;
    end
  end

  // prescaler
  always_comb begin
    pre_nxt = pre_r + 3'h1;
    if (realign)
      pre_nxt = pit_pkg::PRESCALE_START;
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      pre_r <= 3'h0;
    end else begin
      pre_r <= pre_nxt;
    end
  end

  // short mode adds one at stage 8, leaving the low stages frozen
  always_comb begin
    if (ctl_r[pit_pkg::CTL_SHORT_BIT])
      inc = 24'h000100;
    else
      inc = 24'h000001;
  end

  // selected stage is one of the top sixteen
  assign sel_bit = cnt_r[pit_pkg::CNT_LOW_BYPASS + sel_idx];

  // counter: clear beats set beats counting
  always_comb begin
    cnt_nxt = cnt_r;
    if (force_clr)
      cnt_nxt = 24'h000000;
    else if (force_set)
      cnt_nxt = 24'hffffff;
    else if (tick && !hold)
      cnt_nxt = cnt_r + inc;
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      cnt_r <= 24'h000000;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // registered timer output
  always_comb begin
    out_nxt = sel_bit;
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      out_r <= 1'b0;
    end else begin
      out_r <= out_nxt;
    end
  end

  // flag: one event per output period, so a missed clear never doubles it
  assign fall_evt = out_r && !sel_bit;
  always_comb begin
    flag_nxt = flag_r;
    // an event in the cycle of a control write wins over the clear
    if (fall_evt)
      flag_nxt = 1'b1;
    else if (ctl_wr)
      flag_nxt = 1'b0;
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  assign timer_out              = out_r;
  assign link.cpu_flag_line_two = flag_r && grouped;
  assign link.irq               = flag_r && irq_link_jumper_in;
endmodule // pit_timer

// File: rtl/pit_host.sv
// host cpu end: machine cycle timing and grouped i/o output commands
`timescale 1ns/1ps
module pit_host (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  // software port
  input  wire logic [1:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic [7:0]      rdata_out,
  // link
  pit_link_if.host        link
);
  logic [2:0] phase_r, phase_nxt;
  logic       stb_r, stb_nxt;
  logic [2:0] cmd_r, cmd_nxt;
  logic [7:0] data_r, data_nxt;
  logic [7:0] rdata_r, rdata_nxt;

  // write to HOST_ADDR_GROUP sends command 1, to HOST_ADDR_CTL command 3
  always_comb begin
    phase_nxt = phase_r + 3'h1;
    stb_nxt   = 1'b0;
    cmd_nxt   = cmd_r;
    data_nxt  = data_r;
    rdata_nxt = 8'h00;
    if (wr_in && addr_in == pit_pkg::HOST_ADDR_GROUP) begin
      stb_nxt  = 1'b1;
      cmd_nxt  = pit_pkg::CMD_GROUP_SEL;
      data_nxt = wdata_in;
    end else if (wr_in && addr_in == pit_pkg::HOST_ADDR_CTL) begin
      stb_nxt  = 1'b1;
      cmd_nxt  = pit_pkg::CMD_TIMER_CTL;
      data_nxt = wdata_in;
    end
    if (rd_in && addr_in == pit_pkg::HOST_ADDR_STATUS)
      rdata_nxt = {6'h00, link.irq, link.cpu_flag_line_two};
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      phase_r <= 3'h0;
      stb_r   <= 1'b0;
      cmd_r   <= 3'h0;
      data_r  <= 8'h00;
      rdata_r <= 8'h00;
    end else begin
      phase_r <= phase_nxt;
      stb_r   <= stb_nxt;
      cmd_r   <= cmd_nxt;
      data_r  <= data_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign link.io_strobe            = stb_r;
  assign link.io_cmd               = cmd_r;
  assign link.io_data              = data_r;
  assign link.address_timing_pulse = phase_r == pit_pkg::MCYC_ADDR_PHASE;
  assign link.data_timing_pulse    = phase_r == pit_pkg::MCYC_DATA_PHASE;
  assign rdata_out                 = rdata_r;
endmodule // pit_host

// File: verification/pit_link_asserts.sv
// concurrent checks on the link between host and timer ends
`timescale 1ns/1ps
module pit_link_asserts (
  // clock and reset
  input wire logic       clk_in,
  input wire logic       resetn_in,
  // link signals
  input wire logic       io_strobe,
  input wire logic [2:0] io_cmd,
  input wire logic [7:0] io_data,
  input wire logic       address_timing_pulse,
  input wire logic       data_timing_pulse,
  input wire logic       cpu_flag_line_two,
  input wire logic       irq
);
  logic [7:0] grp_r, grp_nxt;
  logic       clr_r, clr_nxt;
  // shadow of group latch and clear bit, ext clear unseen so only a weaker view
  always_comb begin
    grp_nxt = (io_strobe && io_cmd == pit_pkg::CMD_GROUP_SEL) ? io_data : grp_r;
    clr_nxt = clr_r;
    if (io_strobe && io_cmd == pit_pkg::CMD_TIMER_CTL && grp_r == pit_pkg::GROUP_TIMER)
      clr_nxt = io_data[pit_pkg::CTL_CLR_BIT];
    if (!resetn_in) begin
      grp_nxt = pit_pkg::GROUP_NONE;
      clr_nxt = 1'b1;
    end
  end
  always_ff @(posedge clk_in) begin
    grp_r <= grp_nxt;
    clr_r <= clr_nxt;
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  sequence atp_gap_s; !address_timing_pulse [*7] ##1 address_timing_pulse; endsequence
  sequence dtp_gap_s; !data_timing_pulse [*7] ##1 data_timing_pulse; endsequence
  atp_period_a: assert property (address_timing_pulse |=> atp_gap_s)
    else $error("address pulse period off");
  dtp_period_a: assert property (data_timing_pulse |=> dtp_gap_s)
    else $error("data pulse period off");
  pulse_phase_a: assert property (address_timing_pulse |-> ##4 data_timing_pulse)
    else $error("pulse phase off");
  flag_group_a: assert property (cpu_flag_line_two |-> grp_r == pit_pkg::GROUP_TIMER)
    else $error("flag shown without group");
  flag_stands_a: assert property ($fell(cpu_flag_line_two) |-> $past(io_strobe))
    else $error("flag dropped without write");
  clear_quiet_a: assert property ($rose(irq) |->
      !(clr_r && $past(clr_r) && $past(clr_r, 2) && $past(clr_r, 3)))
    else $error("flag rose under clear");
  strobe_cmd_a: assert property (io_strobe |-> io_cmd inside {3'h1, 3'h3})
    else $error("unknown command");
  reset_group_a: assert property (disable iff (1'b0) !resetn_in |=> !cpu_flag_line_two && !irq)
    else $error("flag after reset");
endmodule // pit_link_asserts

// File: verification/testbench.sv
// self-checking bench joining host and timer ends
`timescale 1ns/1ps
module testbench;
  logic        clk_in = 1'b0, resetn_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
  logic        ext_clear_in = 1'b0, jmp = 1'b1, timer_out;
  logic [1:0]  addr_in = 2'h0;
  logic [7:0]  wdata_in = 8'h00, rdata_out, v, d;
  logic [31:0] n, h;
  int          fails = 0, comparisons = 0, seed = 3394, i;
  pit_link_if link ();
  pit_host u_pit_host (.clk_in(clk_in), .resetn_in(resetn_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .link(link));
  pit_timer u_pit_timer (.clk_in(clk_in), .resetn_in(resetn_in), .link(link),
    .ext_clear_in(ext_clear_in), .irq_link_jumper_in(jmp), .timer_out(timer_out));
  pit_link_asserts u_pit_link_asserts (.clk_in(clk_in), .resetn_in(resetn_in),
    .io_strobe(link.io_strobe), .io_cmd(link.io_cmd), .io_data(link.io_data),
    .address_timing_pulse(link.address_timing_pulse), .data_timing_pulse(link.data_timing_pulse),
    .cpu_flag_line_two(link.cpu_flag_line_two), .irq(link.irq));
  initial forever #20 clk_in = ~clk_in;
  function automatic logic [31:0] exp_per(input logic [7:0] c);
    return 32'h10 << (5'(c[3:0]) + (c[4] ? 5'h0 : 5'h8));
  endfunction
  task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %0h seen %0h", s, exp, seen);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] c);
    @(posedge clk_in);
    {addr_in, wdata_in, wr_in} <= {a, c, 1'b1};
    @(posedge clk_in);
    wr_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    #1;
  endtask
  task automatic rd(input logic [1:0] a);
    @(posedge clk_in);
    {addr_in, rd_in} <= {a, 1'b1};
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 v = rdata_out;
  endtask
  // bounded wait for a level, sampled at the falling edge to stay clear of updates
  task automatic till(input logic lvl);
    n = 0;
    while (timer_out !== lvl && n < 32'h4000) begin
      @(negedge clk_in);
      n++;
    end
  endtask
  task automatic close_out;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    jmp = 1'($random(seed));
    repeat (2) @(posedge clk_in);
    resetn_in <= 1'b1;
    rd(2'h2);
    chk("status", v, 8'h00);
    rd(2'h3);
    chk("unmapped", v, 8'h00);
    wr(2'h1, pit_pkg::GROUP_NONE);
    wr(2'h0, 8'h20);
    chk("ungrouped", timer_out, 1'b0);
    wr(2'h1, pit_pkg::GROUP_TIMER);
    wr(2'h0, 8'h20);
    chk("set", timer_out, 1'b1);
    wr(2'h0, 8'hd1);
    chk("clear", timer_out, 1'b0);
    $display("test control done");
    wr(2'h0, 8'h11);
    till(1'b1);
    rd(2'h2);
    chk("half", v, 8'h00);
    till(1'b0);
    rd(2'h2);
    chk("flag", v, {6'h00, jmp, 1'b1});
    wr(2'h0, 8'h91);
    rd(2'h2);
    chk("ack", v, 8'h00);
    n = 32'(timer_out);
    repeat (100) @(negedge clk_in);
    chk("hold", timer_out, n);
    $display("test flag done");
    wr(2'h0, 8'h11);
    @(posedge clk_in) ext_clear_in <= 1'b1;
    repeat (200) @(negedge clk_in);
    chk("ext clear", timer_out, 1'b0);
    @(posedge clk_in) ext_clear_in <= 1'b0;
    $display("test ext clear done");
    for (i = 0; i < 4; i++) begin
      d = (i == 3) ? 8'h00 : (8'h10 | 8'($random(seed) & 3));
      wr(2'h0, 8'hc0 | d);
      wr(2'h0, d);
      till(1'b1);
      till(1'b0);
      h = n;
      till(1'b1);
      chk("period", h + n, exp_per(d));
    end
    $display("test period done");
    close_out;
  end
  initial begin
    repeat (40000) @(posedge clk_in);
    fails++;
    close_out;
  end
endmodule // testbench
